// file: hw/axis_status_event_flags.v
`timescale 1ns/100ps
`include "axis_flags_consts.vh"

module axis_status_event_flags (
	input  wire                   sys_clk,
	input  wire                   reset_n,
	input  wire [`ADDR_W-1:0]     reg_addr,
	input  wire [`DATA_W-1:0]     reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output wire [`DATA_W-1:0]     reg_rdata,
	output wire                   irq,
	output wire                   drive_enable_out,
	input  wire                   drive_enable_pin,
	input  wire                   axis_fault_pin,
	input  wire                   reg1_pin,
	input  wire                   reg2_pin,
	input  wire                   watch_hit,
	input  wire                   module_fault_evt,
	input  wire                   offset_done,
	input  wire                   motion_supersede,
	input  wire                   config_reply_ok,
	input  wire                   config_reply_fail,
	input  wire [`ERR_CODE_W-1:0] config_err_code,
	input  wire [`ERR_ID_W-1:0]   config_err_id,
	output wire                   config_update_pending,
	output wire                   servo_loop_active,
	output wire                   axis_shutdown_state,
	output wire                   major_fault,
	output wire                   minor_fault
);
	// synchronised pins
	wire                   drive_enable_state;
	wire                   axis_fault_sync;
	wire                   reg1_sync;
	wire                   reg2_sync;

	// pin history for edge detection
	reg                    reg1_prev_reg;
	reg                    reg2_prev_reg;
	reg                    axis_fault_prev_reg;
	wire                   reg1_edge;
	wire                   reg2_edge;

	// command decode
	wire                   wr_command;
	wire                   wr_severity;
	wire                   wr_irq_status;
	wire                   wr_irq_mask;
	wire [`CMD_W-1:0]      cmd;

	// flag registers
	reg                    offset_profile_active_reg;
	reg                    offset_profile_active_next;
	reg                    servo_loop_active_reg;
	reg                    servo_loop_active_next;
	reg                    axis_shutdown_state_reg;
	reg                    axis_shutdown_state_next;
	reg                    config_update_pending_reg;
	reg                    config_update_pending_next;
	reg                    axis_fault_flag_reg;
	reg                    module_fault_flag_reg;
	reg                    module_fault_flag_next;
	reg                    config_fault_flag_reg;
	reg                    config_fault_flag_next;

	// event flag pairs
	wire                   watch_armed;
	wire                   watch_occurred;
	wire                   watch_evt;
	wire                   reg1_armed;
	wire                   reg1_occurred;
	wire                   reg1_evt;
	wire                   reg2_armed;
	wire                   reg2_occurred;
	wire                   reg2_evt;

	// software registers
	reg  [`SEV_W-1:0]      severity_reg;
	reg  [`IRQ_W-1:0]      irq_status_reg;
	reg  [`IRQ_W-1:0]      irq_status_next;
	reg  [`IRQ_W-1:0]      irq_mask_reg;
	reg  [`IRQ_W-1:0]      irq_events;
	reg  [`ERR_CODE_W-1:0] err_code_reg;
	reg  [`ERR_ID_W-1:0]   err_id_reg;
	reg  [`DATA_W-1:0]     rdata_reg;
	reg  [`DATA_W-1:0]     rdata_next;
	wire [`ST_W-1:0]       status_word;
	reg                    major_fault_reg;
	reg                    minor_fault_reg;
	wire                   major_next;
	wire                   minor_next;
	wire                   offset_end;

	// pin synchronisers
	sync_2ff #(
		.WIDTH (4)
	) pin_sync (
		.sys_clk  (sys_clk),
		.reset_n  (reset_n),
		.async_in ({drive_enable_pin, axis_fault_pin, reg1_pin, reg2_pin}),
		.sync_out ({drive_enable_state, axis_fault_sync, reg1_sync, reg2_sync})
	);

	// rising edge of registration inputs, from synchronised levels only
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			reg1_prev_reg       <= 1'b0;
			reg2_prev_reg       <= 1'b0;
			axis_fault_prev_reg <= 1'b0;
		end
		else
		begin
			reg1_prev_reg       <= reg1_sync;
			reg2_prev_reg       <= reg2_sync;
			axis_fault_prev_reg <= axis_fault_flag_reg;
		end
	end

	assign reg1_edge = reg1_sync & ~reg1_prev_reg;
	assign reg2_edge = reg2_sync & ~reg2_prev_reg;

	// write address decode
	assign wr_command    = reg_wr & (reg_addr == `ADDR_COMMAND);
	assign wr_severity   = reg_wr & (reg_addr == `ADDR_SEVERITY);
	assign wr_irq_status = reg_wr & (reg_addr == `ADDR_IRQ_STATUS);
	assign wr_irq_mask   = reg_wr & (reg_addr == `ADDR_IRQ_MASK);

	// command bits act for one cycle only
	assign cmd = wr_command ? reg_wdata[`CMD_W-1:0] : {`CMD_W{1'b0}};

	// watch event flags
	arm_event_pair watch_pair (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.arm         (cmd[`CMD_ARM_WATCH]),
		.disarm      (cmd[`CMD_DISARM_WATCH]),
		.hit         (watch_hit),
		.armed       (watch_armed),
		.occurred    (watch_occurred),
		.event_pulse (watch_evt)
	);

	// registration input 1 flags
	arm_event_pair reg1_pair (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.arm         (cmd[`CMD_ARM_REG1]),
		.disarm      (cmd[`CMD_DISARM_REG1]),
		.hit         (reg1_edge),
		.armed       (reg1_armed),
		.occurred    (reg1_occurred),
		.event_pulse (reg1_evt)
	);

	// registration input 2 flags
	arm_event_pair reg2_pair (
		.sys_clk     (sys_clk),
		.reset_n     (reset_n),
		.arm         (cmd[`CMD_ARM_REG2]),
		.disarm      (cmd[`CMD_DISARM_REG2]),
		.hit         (reg2_edge),
		.armed       (reg2_armed),
		.occurred    (reg2_occurred),
		.event_pulse (reg2_evt)
	);

	// profile ends by completion, supersession, abort or shutdown
	assign offset_end = offset_done | motion_supersede | cmd[`CMD_OFFSET_ABORT]
		| axis_shutdown_state_next;

	// next state of axis and fault flags
	always @*
	begin
		// module fault sticks until reconfiguration
		module_fault_flag_next = module_fault_evt
			| (module_fault_flag_reg & ~cmd[`CMD_RECONFIGURE]);
		// shutdown entered by command or module fault, left by reset command while no module fault is held
		if (cmd[`CMD_SHUTDOWN] | module_fault_evt)
			axis_shutdown_state_next = 1'b1;
		else if (cmd[`CMD_SHUTDOWN_RST] & ~module_fault_flag_reg)
			axis_shutdown_state_next = 1'b0;
		else
			axis_shutdown_state_next = axis_shutdown_state_reg;
		// servo loop closes on command, opens on disable or shutdown
		if (cmd[`CMD_SERVO_OFF] | axis_shutdown_state_next)
			servo_loop_active_next = 1'b0;
		else if (cmd[`CMD_SERVO_ON])
			servo_loop_active_next = 1'b1;
		else
			servo_loop_active_next = servo_loop_active_reg;
		// master offset profile runs until ended
		if (offset_end)
			offset_profile_active_next = 1'b0;
		else if (cmd[`CMD_OFFSET_START])
			offset_profile_active_next = 1'b1;
		else
			offset_profile_active_next = offset_profile_active_reg;
		// update pending from host start until any reply
		if (cmd[`CMD_CFG_UPDATE])
			config_update_pending_next = 1'b1;
		else if (config_reply_ok | config_reply_fail)
			config_update_pending_next = 1'b0;
		else
			config_update_pending_next = config_update_pending_reg;
		// failed update raises config fault until reconfiguration
		config_fault_flag_next = config_reply_fail
			| (config_fault_flag_reg & ~cmd[`CMD_RECONFIGURE]);
	end

	// flag storage, all cleared on reset
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			offset_profile_active_reg <= 1'b0;
			servo_loop_active_reg     <= 1'b0;
			axis_shutdown_state_reg   <= 1'b0;
			config_update_pending_reg <= 1'b0;
			axis_fault_flag_reg       <= 1'b0;
			module_fault_flag_reg     <= 1'b0;
			config_fault_flag_reg     <= 1'b0;
		end
		else
		begin
			offset_profile_active_reg <= offset_profile_active_next;
			servo_loop_active_reg     <= servo_loop_active_next;
			axis_shutdown_state_reg   <= axis_shutdown_state_next;
			config_update_pending_reg <= config_update_pending_next;
			axis_fault_flag_reg       <= axis_fault_sync;
			module_fault_flag_reg     <= module_fault_flag_next;
			config_fault_flag_reg     <= config_fault_flag_next;
		end
	end

	// attribute error capture on a failed update
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			err_code_reg <= {`ERR_CODE_W{1'b0}};
			err_id_reg   <= {`ERR_ID_W{1'b0}};
		end
		else if (config_reply_fail)
		begin
			err_code_reg <= config_err_code;
			err_id_reg   <= config_err_id;
		end
	end

	// fault severity classification
	assign major_next = (axis_fault_flag_reg & severity_reg[`SEV_AXIS])
		| (module_fault_flag_reg & severity_reg[`SEV_MOD])
		| (config_fault_flag_reg & severity_reg[`SEV_CFG]);
	assign minor_next = (axis_fault_flag_reg & ~severity_reg[`SEV_AXIS])
		| (module_fault_flag_reg & ~severity_reg[`SEV_MOD])
		| (config_fault_flag_reg & ~severity_reg[`SEV_CFG]);

	// severity register and classified fault outputs
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			severity_reg    <= {`SEV_W{1'b0}};
			major_fault_reg <= 1'b0;
			minor_fault_reg <= 1'b0;
		end
		else
		begin
			if (wr_severity)
				severity_reg <= reg_wdata[`SEV_W-1:0];
			major_fault_reg <= major_next;
			minor_fault_reg <= minor_next;
		end
	end

	// interrupt sources, each a one-cycle event
	always @*
	begin
		irq_events                   = {`IRQ_W{1'b0}};
		irq_events[`IRQ_WATCH]       = watch_evt;
		irq_events[`IRQ_REG1]        = reg1_evt;
		irq_events[`IRQ_REG2]        = reg2_evt;
		irq_events[`IRQ_AXIS_FLT]    = axis_fault_flag_reg & ~axis_fault_prev_reg;
		irq_events[`IRQ_MOD_FLT]     = module_fault_evt;
		irq_events[`IRQ_CFG_FLT]     = config_reply_fail;
		irq_events[`IRQ_CFG_DONE]    = config_reply_ok;
		irq_events[`IRQ_OFFSET_DONE] = offset_profile_active_reg & offset_done;
	end

	// write one to clear; a new event wins over the clear
	always @*
	begin
		irq_status_next = irq_status_reg;
		if (wr_irq_status)
			irq_status_next = irq_status_reg & ~reg_wdata[`IRQ_W-1:0];
		irq_status_next = irq_status_next | irq_events;
	end

	// interrupt status and mask registers
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_status_reg <= {`IRQ_W{1'b0}};
			irq_mask_reg   <= {`IRQ_W{1'b0}};
		end
		else
		begin
			irq_status_reg <= irq_status_next;
			if (wr_irq_mask)
				irq_mask_reg <= reg_wdata[`IRQ_W-1:0];
		end
	end

	// level interrupt from any unmasked status bit
	assign irq = |(irq_status_reg & irq_mask_reg);

	// assembled status word
	assign status_word = {reg2_occurred, reg2_armed, reg1_occurred, reg1_armed,
		watch_occurred, watch_armed, config_fault_flag_reg,
		module_fault_flag_reg, axis_fault_flag_reg, config_update_pending_reg,
		axis_shutdown_state_reg, drive_enable_state, servo_loop_active_reg,
		offset_profile_active_reg};

	// read multiplexer; unmapped addresses read zero
	always @*
	begin
		rdata_next = {`DATA_W{1'b0}};
		case (reg_addr)
			`ADDR_STATUS:
				rdata_next[`ST_W-1:0] = status_word;
			`ADDR_SEVERITY:
				rdata_next[`SEV_W-1:0] = severity_reg;
			`ADDR_IRQ_STATUS:
				rdata_next[`IRQ_W-1:0] = irq_status_reg;
			`ADDR_IRQ_MASK:
				rdata_next[`IRQ_W-1:0] = irq_mask_reg;
			`ADDR_CFG_ERROR:
			begin
				rdata_next[`ERR_CODE_W-1:0] = err_code_reg;
				rdata_next[`ERR_ID_LSB+`ERR_ID_W-1:`ERR_ID_LSB] = err_id_reg;
			end
			default:
				rdata_next = {`DATA_W{1'b0}};
		endcase
	end

	// read data stand only in the cycle after the strobe
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rdata_reg <= {`DATA_W{1'b0}};
		else if (reg_rd)
			rdata_reg <= rdata_next;
		else
			rdata_reg <= {`DATA_W{1'b0}};
	end

	// outputs
	assign reg_rdata             = rdata_reg;
	assign drive_enable_out      = servo_loop_active_reg;
	assign config_update_pending = config_update_pending_reg;
	assign servo_loop_active     = servo_loop_active_reg;
	assign axis_shutdown_state   = axis_shutdown_state_reg;
	assign major_fault           = major_fault_reg;
	assign minor_fault           = minor_fault_reg;
endmodule

// file: hw/axis_flags_consts.vh
`ifndef AXIS_FLAGS_CONSTS_VH
`define AXIS_FLAGS_CONSTS_VH

// register word addresses
`define ADDR_W            8
`define DATA_W            32
`define ADDR_STATUS       8'h00
`define ADDR_COMMAND      8'h04
`define ADDR_SEVERITY     8'h08
`define ADDR_IRQ_STATUS   8'h0C
`define ADDR_IRQ_MASK     8'h10
`define ADDR_CFG_ERROR    8'h14

// status word bit positions
`define ST_OFFSET         0
`define ST_SERVO          1
`define ST_DRIVE          2
`define ST_SHUTDOWN       3
`define ST_CFG_PEND       4
`define ST_AXIS_FLT       5
`define ST_MOD_FLT        6
`define ST_CFG_FLT        7
`define ST_WATCH_ARM      8
`define ST_WATCH_OCC      9
`define ST_REG1_ARM       10
`define ST_REG1_OCC       11
`define ST_REG2_ARM       12
`define ST_REG2_OCC       13
`define ST_W              14

// command word bits, each a one-cycle action on write
`define CMD_ARM_WATCH     0
`define CMD_DISARM_WATCH  1
`define CMD_ARM_REG1      2
`define CMD_DISARM_REG1   3
`define CMD_ARM_REG2      4
`define CMD_DISARM_REG2   5
`define CMD_SERVO_ON      6
`define CMD_SERVO_OFF     7
`define CMD_OFFSET_START  8
`define CMD_OFFSET_ABORT  9
`define CMD_CFG_UPDATE    10
`define CMD_RECONFIGURE   11
`define CMD_SHUTDOWN      12
`define CMD_SHUTDOWN_RST  13
`define CMD_W             14

// severity bits: one means major fault
`define SEV_AXIS          0
`define SEV_MOD           1
`define SEV_CFG           2
`define SEV_W             3

// interrupt status and mask bits
`define IRQ_WATCH         0
`define IRQ_REG1          1
`define IRQ_REG2          2
`define IRQ_AXIS_FLT      3
`define IRQ_MOD_FLT       4
`define IRQ_CFG_FLT       5
`define IRQ_CFG_DONE      6
`define IRQ_OFFSET_DONE   7
`define IRQ_W             8

// attribute error capture
`define ERR_CODE_W        8
`define ERR_ID_W          16
`define ERR_ID_LSB        8

`endif

// file: hw/sync_2ff.v
`timescale 1ns/100ps
// two-stage synchroniser for asynchronous pin levels
module sync_2ff #(
	parameter WIDTH = 1
)(
	input  wire             sys_clk,
	input  wire             reset_n,
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_reg;
	reg [WIDTH-1:0] sync_reg;

	// first stage feeds only the second
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_reg <= {WIDTH{1'b0}};
			sync_reg <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

// file: hw/arm_event_pair.v
`timescale 1ns/100ps
// armed / occurred flag pair for watch and registration events
module arm_event_pair (
	input  wire sys_clk,
	input  wire reset_n,
	input  wire arm,
	input  wire disarm,
	input  wire hit,
	output wire armed,
	output wire occurred,
	output wire event_pulse
);
	reg  armed_reg;
	reg  occurred_reg;
	wire armed_next;
	wire occurred_next;
	wire fire;

	// an event only counts while armed
	assign fire = hit & armed_reg;

	// arm wins over the clearing event in the same cycle
	assign armed_next = arm | (armed_reg & ~fire & ~disarm);

	// event wins over the clearing command in the same cycle
	assign occurred_next = fire | (occurred_reg & ~arm & ~disarm);

	// flag storage, cleared on reset
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			armed_reg    <= 1'b0;
			occurred_reg <= 1'b0;
		end
		else
		begin
			armed_reg    <= armed_next;
			occurred_reg <= occurred_next;
		end
	end

	assign armed       = armed_reg;
	assign occurred    = occurred_reg;
	assign event_pulse = fire;
endmodule

// file: tb/axis_flags_monitor.sv
`timescale 1ns/100ps
`include "axis_flags_consts.vh"

// port-level checks of the axis flag block
module axis_flags_monitor (
	input wire                   sys_clk,
	input wire                   reset_n,
	input wire [`ADDR_W-1:0]     reg_addr,
	input wire [`DATA_W-1:0]     reg_wdata,
	input wire                   reg_wr,
	input wire                   reg_rd,
	input wire [`DATA_W-1:0]     reg_rdata,
	input wire                   irq,
	input wire                   drive_enable_out,
	input wire                   drive_enable_pin,
	input wire                   module_fault_evt,
	input wire                   config_reply_ok,
	input wire                   config_reply_fail,
	input wire                   config_update_pending,
	input wire                   servo_loop_active,
	input wire                   axis_shutdown_state,
	input wire                   major_fault,
	input wire                   minor_fault
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);

	// command and read strobes from the register port, and reply and fault events
	sequence s_servo_off;
		reg_wr && reg_addr == `ADDR_COMMAND && reg_wdata[`CMD_SERVO_OFF];
	endsequence
	sequence s_servo_on;
		reg_wr && reg_addr == `ADDR_COMMAND && reg_wdata[`CMD_SERVO_ON]
			&& !reg_wdata[`CMD_SERVO_OFF] && !reg_wdata[`CMD_SHUTDOWN]
			&& !module_fault_evt && !axis_shutdown_state;
	endsequence
	sequence s_shut_entry;
		module_fault_evt || (reg_wr && reg_addr == `ADDR_COMMAND && reg_wdata[`CMD_SHUTDOWN]);
	endsequence
	sequence s_cfg_start;
		reg_wr && reg_addr == `ADDR_COMMAND && reg_wdata[`CMD_CFG_UPDATE];
	endsequence
	sequence s_cfg_reply;
		(config_reply_ok || config_reply_fail)
			&& !(reg_wr && reg_addr == `ADDR_COMMAND && reg_wdata[`CMD_CFG_UPDATE]);
	endsequence
	sequence s_fault_evt;
		config_reply_fail || module_fault_evt;
	endsequence
	sequence s_status_rd;
		reg_rd && reg_addr == `ADDR_STATUS;
	endsequence

	property p_servo_off;
		s_servo_off |=> !servo_loop_active;
	endproperty
	property p_servo_on;
		s_servo_on |=> servo_loop_active;
	endproperty
	// status drive bit is the pin level three samples before the answer
	property p_drive;
		s_status_rd |=> reg_rdata[`ST_DRIVE] == $past(drive_enable_pin, 3);
	endproperty
	property p_shut;
		s_shut_entry |=> axis_shutdown_state && !servo_loop_active && !drive_enable_out;
	endproperty
	property p_cfg_start;
		s_cfg_start |=> config_update_pending;
	endproperty
	property p_cfg_reply;
		s_cfg_reply |=> !config_update_pending;
	endproperty
	property p_reset;
		$rose(reset_n) |-> !irq && reg_rdata == 0 && !config_update_pending
			&& !servo_loop_active && !axis_shutdown_state && !major_fault && !minor_fault;
	endproperty
	// a new fault is classified two edges later, whatever its severity
	property p_sev;
		s_fault_evt |=> ##1 (major_fault || minor_fault);
	endproperty
	property p_rd_cmd;
		reg_rd && reg_addr == `ADDR_COMMAND |=> reg_rdata == 0;
	endproperty
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 0;
	endproperty

	a_servo_off: assert property (p_servo_off)
		else $error("servo flag still set after servo off");
	a_servo_on: assert property (p_servo_on)
		else $error("servo flag not set after servo on");
	a_drive: assert property (p_drive)
		else $error("status drive bit differs from drive enable pin");
	a_shut: assert property (p_shut)
		else $error("shutdown entry not reflected");
	a_cfg_start: assert property (p_cfg_start)
		else $error("update pending not set");
	a_cfg_reply: assert property (p_cfg_reply)
		else $error("update pending not cleared by reply");
	a_reset: assert property (p_reset)
		else $error("outputs not clear after reset");
	a_sev: assert property (p_sev)
		else $error("fault not classified as major or minor");
	a_rd_cmd: assert property (p_rd_cmd)
		else $error("command register read not zero");
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside read answer");
endmodule

bind axis_status_event_flags axis_flags_monitor mon_u (.sys_clk, .reset_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq, .drive_enable_out, .drive_enable_pin,
	.module_fault_evt,
	.config_reply_ok, .config_reply_fail, .config_update_pending, .servo_loop_active,
	.axis_shutdown_state, .major_fault, .minor_fault);

// file: tb/axis_side_model.sv
`timescale 1ns/100ps

// physical axis: drive enable readback, fault level, registration sensors
module axis_side_model (
	input  wire       sys_clk,
	input  wire       drive_enable_out,
	input  wire       fault_req,
	input  wire [1:0] reg_req,
	output reg        drive_enable_pin = 1'b0,
	output reg        axis_fault_pin = 1'b0,
	output wire       reg1_pin,
	output wire       reg2_pin
);
	integer cnt1 = 0;
	integer cnt2 = 0;

	// amplifier echoes its enable a cycle late; sensors hold an edge four cycles
	always @(posedge sys_clk)
	begin
		drive_enable_pin <= drive_enable_out;
		axis_fault_pin   <= fault_req;
		cnt1 <= reg_req[0] ? 4 : (cnt1 > 0 ? cnt1 - 1 : 0);
		cnt2 <= reg_req[1] ? 4 : (cnt2 > 0 ? cnt2 - 1 : 0);
	end
	assign reg1_pin = cnt1 > 0;
	assign reg2_pin = cnt2 > 0;
endmodule

// file: tb/axis_status_event_flags_tb.sv
`timescale 1ns/100ps
`include "axis_flags_consts.vh"

module axis_status_event_flags_tb;
	reg                    sys_clk = 1'b0;
	reg                    reset_n = 1'b0;
	reg  [`ADDR_W-1:0]     reg_addr = 8'h00;
	reg  [`DATA_W-1:0]     reg_wdata = 32'h0000_0000;
	reg                    reg_wr = 1'b0;
	reg                    reg_rd = 1'b0;
	reg  [5:0]             evt = 6'h00;
	reg                    fault_req = 1'b0;
	reg  [1:0]             reg_req = 2'h0;
	reg  [`ERR_CODE_W-1:0] err_code = 8'h00;
	reg  [`ERR_ID_W-1:0]   err_id = 16'h0000;
	wire [`DATA_W-1:0]     reg_rdata;
	wire                   irq, drv_out, drv_pin, flt_pin, r1_pin, r2_pin;
	wire                   pend, servo, shut, major, minor;
	integer                fail_count = 0;
	integer                cmp_count = 0;
	integer                cycles = 0;
	integer                st = 0;
	integer                i, k, c;

	axis_status_event_flags dut_u (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .drive_enable_out(drv_out), .drive_enable_pin(drv_pin),
		.axis_fault_pin(flt_pin), .reg1_pin(r1_pin), .reg2_pin(r2_pin), .watch_hit(evt[0]),
		.module_fault_evt(evt[1]), .offset_done(evt[2]), .motion_supersede(evt[3]),
		.config_reply_ok(evt[4]), .config_reply_fail(evt[5]), .config_err_code(err_code),
		.config_err_id(err_id), .config_update_pending(pend), .servo_loop_active(servo),
		.axis_shutdown_state(shut), .major_fault(major), .minor_fault(minor));
	axis_side_model side_u (.sys_clk(sys_clk), .drive_enable_out(drv_out),
		.fault_req(fault_req), .reg_req(reg_req), .drive_enable_pin(drv_pin),
		.axis_fault_pin(flt_pin), .reg1_pin(r1_pin), .reg2_pin(r2_pin));

	// clock and hang guard
	initial
	begin
		forever #20 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cycles = cycles + 1;
		if (cycles == 20000)
		begin
			fail_count = fail_count + 1;
			conclude;
		end
	end

	task conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp)
		begin
			fail_count = fail_count + 1;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		chk(n, reg_rdata, e);
	endtask
	// status read once pin readback has settled; drive bit follows servo
	task stat;
		repeat (6) @(posedge sys_clk);
		st[`ST_DRIVE] = st[`ST_SERVO];
		rdchk("status", `ADDR_STATUS, st);
	endtask
	task irqchk(input logic e);
		@(negedge sys_clk);
		chk("irq", irq, e);
	endtask
	task pulse(input integer b);
		@(posedge sys_clk);
		evt[b] <= 1'b1;
		@(posedge sys_clk);
		evt <= 6'h00;
	endtask
	// watch hit or a registration edge from the axis side
	task fire(input integer n);
		if (n == 0)
			pulse(0);
		else
		begin
			@(posedge sys_clk);
			reg_req[n - 1] <= 1'b1;
			@(posedge sys_clk);
			reg_req <= 2'h0;
		end
		repeat (8) @(posedge sys_clk);
	endtask

	// main sequence
	initial
	begin
		void'($urandom(33525));
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		rdchk("status", `ADDR_STATUS, 0);
		rdchk("command", `ADDR_COMMAND, 0);
		rdchk("unmapped", 8'h20, 0);
		wr(`ADDR_STATUS, 32'hFFFF_FFFF);
		rdchk("status", `ADDR_STATUS, 0);
		$display("reset test done");
		// unarmed hit, arm, hit, then disarm or re-arm
		wr(`ADDR_IRQ_MASK, 32'h0000_00FF);
		for (k = 0; k < 3; k++)
		begin
			fire(k);
			stat();
			wr(`ADDR_COMMAND, 1 << (2 * k));
			st[8 + 2 * k] = 1;
			stat();
			fire(k);
			st[8 + 2 * k] = 0;
			st[9 + 2 * k] = 1;
			stat();
			rdchk("irq_status", `ADDR_IRQ_STATUS, 1 << k);
			irqchk(1);
			wr(`ADDR_IRQ_STATUS, 1 << k);
			irqchk(0);
			wr(`ADDR_COMMAND, (k == 1 ? 1 : 2) << (2 * k));
			st[8 + 2 * k] = (k == 1);
			st[9 + 2 * k] = 0;
			stat();
		end
		$display("event test done");
		// random servo, offset and shutdown commands
		for (i = 0; i < 24; i++)
		begin
			c = $urandom & 32'h0000_33C0;
			if (st[`ST_SHUTDOWN])
				c = c & ~32'h0000_0140;
			wr(`ADDR_COMMAND, c);
			st[3] = c[`CMD_SHUTDOWN] | (st[3] & ~c[`CMD_SHUTDOWN_RST]);
			st[1] = ~(c[`CMD_SERVO_OFF] | c[`CMD_SHUTDOWN]) & (c[`CMD_SERVO_ON] | st[1]);
			st[0] = ~(c[`CMD_OFFSET_ABORT] | c[`CMD_SHUTDOWN]) & (c[`CMD_OFFSET_START] | st[0]);
			stat();
		end
		wr(`ADDR_COMMAND, 32'h0000_2000);
		st[`ST_SHUTDOWN] = 0;
		wr(`ADDR_IRQ_STATUS, 32'h0000_00FF);
		for (k = 3; k >= 2; k--)
		begin
			wr(`ADDR_COMMAND, 32'h0000_0100);
			st[`ST_OFFSET] = 1;
			stat();
			pulse(k);
			st[`ST_OFFSET] = 0;
			stat();
		end
		rdchk("irq_status", `ADDR_IRQ_STATUS, 32'h0000_0080);
		$display("motion test done");
		// failed update, severity, then restart that succeeds
		wr(`ADDR_IRQ_STATUS, 32'h0000_00FF);
		wr(`ADDR_COMMAND, 32'h0000_0400);
		st[`ST_CFG_PEND] = 1;
		stat();
		@(posedge sys_clk);
		err_code <= 8'($urandom);
		err_id   <= 16'($urandom);
		pulse(5);
		st[`ST_CFG_PEND] = 0;
		st[`ST_CFG_FLT] = 1;
		stat();
		rdchk("cfg_error", `ADDR_CFG_ERROR, {8'h00, err_id, err_code});
		wr(`ADDR_SEVERITY, 32'h0000_0004);
		rdchk("severity", `ADDR_SEVERITY, 32'h0000_0004);
		chk("major", major, 1);
		wr(`ADDR_SEVERITY, 0);
		rdchk("severity", `ADDR_SEVERITY, 0);
		chk("minor", minor, 1);
		wr(`ADDR_COMMAND, 32'h0000_0C00);
		st[`ST_CFG_FLT] = 0;
		pulse(4);
		stat();
		rdchk("irq_status", `ADDR_IRQ_STATUS, 32'h0000_0060);
		$display("config test done");
		// module fault forces shutdown until reconfigured
		pulse(1);
		st[`ST_MOD_FLT] = 1;
		st[3] = 1;
		st[1] = 0;
		stat();
		wr(`ADDR_COMMAND, 32'h0000_2000);
		stat();
		wr(`ADDR_COMMAND, 32'h0000_0800);
		wr(`ADDR_COMMAND, 32'h0000_2000);
		st[`ST_MOD_FLT] = 0;
		st[3] = 0;
		stat();
		$display("module fault test done");
		// axis fault with interrupt masked, then unmasked and cleared
		wr(`ADDR_IRQ_STATUS, 32'h0000_00FF);
		wr(`ADDR_IRQ_MASK, 0);
		@(posedge sys_clk);
		fault_req <= 1'b1;
		st[`ST_AXIS_FLT] = 1;
		stat();
		rdchk("irq_status", `ADDR_IRQ_STATUS, 32'h0000_0008);
		irqchk(0);
		wr(`ADDR_IRQ_MASK, 32'h0000_0008);
		irqchk(1);
		chk("minor", minor, 1);
		wr(`ADDR_SEVERITY, 1);
		rdchk("severity", `ADDR_SEVERITY, 1);
		chk("major", major, 1);
		@(posedge sys_clk);
		fault_req <= 1'b0;
		st[`ST_AXIS_FLT] = 0;
		stat();
		wr(`ADDR_IRQ_STATUS, 32'h0000_0008);
		irqchk(0);
		$display("axis fault test done");
		conclude;
	end
endmodule
